// >>> design/ppcr_pkg.sv
package ppcr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets within each security frame.
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_ESR      = 12'h0f8; // Error status.
  localparam logic [11:0] OFF_PART_SEL = 12'h100; // Partition selector.
  localparam logic [11:0] OFF_PRI      = 12'h400; // Per-partition priority.
  localparam logic [11:0] OFF_MONITOR_INSTANCE_INDEX  = 12'h800; // Monitor selector.
  localparam logic [11:0] OFF_CAPT     = 12'h808; // Capture event trigger.
  localparam logic [11:0] OFF_CSU_CTL  = 12'h818; // Storage monitor control.

  // ----------------------------------------------------------------------
  // Implemented features, as the identification registers report them.
  // ----------------------------------------------------------------------
  localparam logic       DS_SUPPORTED  = 1'h1;  // Downstream priority present.
  localparam logic       INT_SUPPORTED = 1'h1;  // Internal priority present.
  localparam logic [4:0] DS_WIDTH      = 5'h08; // Downstream field width.
  localparam logic [4:0] INT_WIDTH     = 5'h04; // Internal field width.
  localparam logic       DS_ZERO_LOW   = 1'h1;  // Downstream: zero is lowest.
  localparam logic       INT_ZERO_LOW  = 1'h0;  // Internal: zero is highest.
  localparam logic       RIS_SUPPORTED = 1'h1;  // Resource instance select.
  localparam logic       NRW_SUPPORTED = 1'h1;  // Partition narrowing.
  localparam logic       CAPT_SUPPORTED = 1'h1; // Monitor capture present.
  localparam logic [5:0] EXT_EVT_IMPL  = 6'h01; // Only external event 1 wired.

  // ----------------------------------------------------------------------
  // Field positions, masks, codes and reset values.
  // ----------------------------------------------------------------------
  localparam int          PS_INTERNAL_BIT = 16;
  localparam int          PS_RIS_LSB      = 24;
  localparam int          CE_NOW_BIT      = 0;
  localparam int          CE_ALL_BIT      = 1;
  localparam int          CTL_EN_BIT      = 31;
  localparam int          CTL_SEL_LSB     = 28;
  localparam int          ESR_RANGE_BIT   = 0;
  localparam logic [31:0] PS_WMASK        = 32'h0101ffff;
  localparam logic [31:0] MS_WMASK        = 32'h01000001;
  localparam logic [31:0] REG_RST         = 32'h00000000;
  localparam logic [2:0]  CAPT_SEL_NONE   = 3'h0;
  localparam logic [2:0]  CAPT_SEL_LOCAL  = 3'h7;

  // ----------------------------------------------------------------------
  // Storage geometry.
  // ----------------------------------------------------------------------
  localparam int PART_IDX_W = 4;                  // Partitions per state: 16.
  localparam int PRI_AW     = PART_IDX_W + 2;     // State, instance, partition.
  localparam int PRI_DEPTH  = 64;
  localparam int NUM_MON    = 4;                  // Monitors per state.

  // ----------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        ns;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ppcr_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } ppcr_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        ns;
    logic [3:0]  resource_instance_select;
    logic [15:0] partition_id;
  } ppcr_txn_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ds_pri;
    logic [15:0] int_pri;
    logic [15:0] ds_rank;
    logic [15:0] int_rank;
  } ppcr_pri_t;

  // Keeps only the implemented low bits; an absent kind reads as zero.
  function automatic logic [15:0] pri_mask(logic [15:0] v, logic has, logic [4:0] wd);
    logic [16:0] m;
    m = (17'h00001 << wd) - 17'h00001;
    return has ? (v & m[15:0]) : 16'h0000;
  endfunction

  // Urgency rank where a larger rank is always more urgent.
  function automatic logic [15:0] pri_rank(logic [15:0] v, logic zero_low, logic [4:0] wd);
    logic [16:0] m;
    m = (17'h00001 << wd) - 17'h00001;
    return zero_low ? v : (~v & m[15:0]);
  endfunction

endpackage

// >>> design/ppcr_pri_store.sv
`timescale 1ns/1ps
module ppcr_pri_store (
  // Clock and reset.
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  // Register write port.
  input  wire logic                        wr_en,
  input  wire logic [ppcr_pkg::PRI_AW-1:0] wr_idx,
  input  wire logic [31:0]                 wr_data,
  // Register read port.
  input  wire logic [ppcr_pkg::PRI_AW-1:0] rd_idx,
  output logic      [31:0]                 rd_data,
  // Transaction lookup port.
  input  wire logic [ppcr_pkg::PRI_AW-1:0] lk_idx,
  output logic      [31:0]                 lk_data
);

  // Settings per security state, resource instance and partition.
  logic [31:0] mem [ppcr_pkg::PRI_DEPTH];

  // ----------------------------------------------------------------------
  // Storage update. Reset clears every entry so no partition starts unknown.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ppcr_pkg::PRI_DEPTH; i++) begin
        mem[i] <= ppcr_pkg::REG_RST;
      end
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Both read ports are combinational; the caller registers the result.
  assign rd_data = mem[rd_idx];
  assign lk_data = mem[lk_idx];

endmodule

// >>> design/ppcr_capture_gen.sv
`timescale 1ns/1ps
module ppcr_capture_gen (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Decoded write to the capture event register.
  input  wire logic        wr_en,
  input  wire logic        wr_ns,
  input  wire logic [31:0] wr_data,
  // One-cycle event pulses per security scope.
  output logic             evt_s,
  output logic             evt_ns
);

  logic now_bit; // Trigger bit of the written word.
  logic all_bit; // Broadcast bit, only honoured from the Secure frame.

  assign now_bit = wr_data[ppcr_pkg::CE_NOW_BIT];
  assign all_bit = wr_data[ppcr_pkg::CE_ALL_BIT] & ~wr_ns;

  // ----------------------------------------------------------------------
  // Event pulses. Nothing is stored, so each write yields one pulse only.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_s  <= 1'b0;
      evt_ns <= 1'b0;
    end else begin
      evt_s  <= wr_en & now_bit & ~wr_ns;
      evt_ns <= wr_en & now_bit & (wr_ns | all_bit);
    end
  end

endmodule

// >>> design/ppcr_regs.sv
// Summary of operation
// - Downstream priority bits 31:16 drive outgoing traffic.
// - Internal priority bits 15:0 used inside component.
// - Unsupported priority kind reads zero, unused.
// - Only implemented low bits of each field kept.
// - Polarity bit decides zero lowest or highest.
// - Separate Secure and Non-secure priority settings.
// - Access indexes selected instance and partition.
// - Trigger bit one fires selector-seven monitors.
// - Trigger bit zero fires nothing at all.
// - Secure broadcast reaches both security states.
// - Secure without broadcast reaches Secure only.
// - Non-secure broadcast bit reads zero, ignored.
// - Capture event register always reads zero.
// - Monitor control addresses selected monitor instance.
// - Enable bit zero stops the monitor collecting.
// - Selector decodes none, external one-six, local.
// - Omitted event sources never cause capture.
// - Without capture support selector reads zero.
// - Selector holds partition identifier bits 15:0.
// - Wrong internal flag logs error, blocks write.
`timescale 1ns/1ps
module ppcr_regs (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // Register access from both security frames.
  input  wire ppcr_pkg::ppcr_req_t     reg_req,
  output ppcr_pkg::ppcr_rsp_t          reg_rsp,
  // Priority lookup for transactions passing through.
  input  wire ppcr_pkg::ppcr_txn_t     txn,
  output ppcr_pkg::ppcr_pri_t          pri_out,
  // External capture event sources 1 to 6.
  input  wire logic [5:0]              ext_capture_evt,
  // Monitor controls; low half Secure, high half Non-secure.
  output logic [2*ppcr_pkg::NUM_MON-1:0] mon_enable,
  output logic [2*ppcr_pkg::NUM_MON-1:0] mon_capture
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [31:0] part_sel [2];                  // Partition selector per state.
  logic [31:0] monitor_instance_index  [2];                  // Monitor selector per state.
  logic [31:0] esr      [2];                  // Error status per state.
  logic [2:0]  ctl_sel  [2*ppcr_pkg::NUM_MON]; // Capture selector per monitor.
  logic [31:0] next_rdata;                    // Read data before the flop.

  // All checks in this module run on the core clock and sleep while reset is held.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------------
  // Access decode.
  // ----------------------------------------------------------------------
  logic                        sec;          // Frame of this access.
  logic                        hit_ps;       // Partition selector.
  logic                        hit_pri;      // Priority settings.
  logic                        hit_ms;       // Monitor selector.
  logic                        hit_capt;     // Capture trigger.
  logic                        hit_ctl;      // Monitor control.
  logic                        hit_esr;      // Error status.
  logic                        nrw_err;      // Internal flag mismatch.
  logic [31:0]                 cur_ps;       // Selector of this frame.
  logic [ppcr_pkg::PRI_AW-1:0] pri_idx;      // Storage slot for the access.
  logic [ppcr_pkg::PRI_AW-1:0] lk_idx;       // Storage slot for the lookup.
  logic [2:0]                  mon_idx;      // Monitor addressed.
  logic [31:0]                 pri_rd;       // Stored value at the access slot.
  logic [31:0]                 lk_rd;        // Stored value at the lookup slot.
  logic [31:0]                 pri_wr;       // Value written to storage.
  logic                        evt_s;        // Secure local capture pulse.
  logic                        evt_ns;       // Non-secure local capture pulse.

  assign sec      = reg_req.ns;
  assign hit_ps   = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_PART_SEL);
  assign hit_pri  = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_PRI);
  assign hit_ms   = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_MONITOR_INSTANCE_INDEX);
  assign hit_capt = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_CAPT);
  assign hit_ctl  = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_CSU_CTL);
  assign hit_esr  = reg_req.valid && (reg_req.addr == ppcr_pkg::OFF_ESR);
  assign cur_ps   = part_sel[sec];

  // Under narrowing the selector must name an internal partition.
  assign nrw_err = ppcr_pkg::NRW_SUPPORTED && !cur_ps[ppcr_pkg::PS_INTERNAL_BIT];

  // The frame picks the state half, so the two halves never alias.
  assign pri_idx = {sec, cur_ps[ppcr_pkg::PS_RIS_LSB] & ppcr_pkg::RIS_SUPPORTED,
                    cur_ps[ppcr_pkg::PART_IDX_W-1:0]};

  // Lookups follow the same layout as register accesses.
  assign lk_idx = {txn.ns, txn.resource_instance_select[0] & ppcr_pkg::RIS_SUPPORTED,
                   txn.partition_id[ppcr_pkg::PART_IDX_W-1:0]};

  // Monitor index: state, instance, monitor within the instance.
  assign mon_idx = {sec, monitor_instance_index[sec][ppcr_pkg::PS_RIS_LSB] & ppcr_pkg::RIS_SUPPORTED,
                    monitor_instance_index[sec][0]};

  // Unimplemented bits are dropped on the way in, so reads need no extra care.
  assign pri_wr = {ppcr_pkg::pri_mask(reg_req.wdata[31:16], ppcr_pkg::DS_SUPPORTED, ppcr_pkg::DS_WIDTH),
                   ppcr_pkg::pri_mask(reg_req.wdata[15:0], ppcr_pkg::INT_SUPPORTED,
                                      ppcr_pkg::INT_WIDTH)};

  // ----------------------------------------------------------------------
  // Priority storage.
  // ----------------------------------------------------------------------
  ppcr_pri_store u_store (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (hit_pri && reg_req.write && !nrw_err),
    .wr_idx   (pri_idx),
    .wr_data  (pri_wr),
    .rd_idx   (pri_idx),
    .rd_data  (pri_rd),
    .lk_idx   (lk_idx),
    .lk_data  (lk_rd)
  );

  // ----------------------------------------------------------------------
  // Local capture event generator.
  // ----------------------------------------------------------------------
  ppcr_capture_gen u_capt (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (hit_capt && reg_req.write),
    .wr_ns    (sec),
    .wr_data  (reg_req.wdata),
    .evt_s    (evt_s),
    .evt_ns   (evt_ns)
  );

  // ----------------------------------------------------------------------
  // Selector registers. Unimplemented fields stay zero.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      part_sel[0] <= ppcr_pkg::REG_RST;
      part_sel[1] <= ppcr_pkg::REG_RST;
    end else if (hit_ps && reg_req.write) begin
      part_sel[sec] <= reg_req.wdata & ppcr_pkg::PS_WMASK;
    end
  end

  // The identifier must land exactly as written in the frame's own selector.
  a_sel_write: assert property (hit_ps && reg_req.write |=>
                                part_sel[$past(sec)][15:0] == $past(reg_req.wdata[15:0]))
    else $error("partition selector write not stored");

  // Monitor selector; only the instance and monitor bits are kept.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      monitor_instance_index[0] <= ppcr_pkg::REG_RST;
      monitor_instance_index[1] <= ppcr_pkg::REG_RST;
    end else if (hit_ms && reg_req.write) begin
      monitor_instance_index[sec] <= reg_req.wdata & ppcr_pkg::MS_WMASK;
    end
  end

  // ----------------------------------------------------------------------
  // Error status. A new error beats a clearing write in the same cycle.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      esr[0] <= ppcr_pkg::REG_RST;
      esr[1] <= ppcr_pkg::REG_RST;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (hit_pri && nrw_err && (sec == s[0])) begin
          esr[s][ppcr_pkg::ESR_RANGE_BIT] <= 1'b1;
        end else if (hit_esr && reg_req.write && (sec == s[0])) begin
          esr[s][ppcr_pkg::ESR_RANGE_BIT] <= reg_req.wdata[ppcr_pkg::ESR_RANGE_BIT];
        end
      end
    end
  end

  // A logged error stays until the owning frame writes the bit back to zero.
  a_esr_sticky: assert property (esr[0][0] && !(hit_esr && reg_req.write && !reg_req.ns)
                                 |=> esr[0][0])
    else $error("error status bit lost without a clearing write");

  // ----------------------------------------------------------------------
  // Monitor control: enable and capture selector for the chosen monitor.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_enable <= '0;
      for (int m = 0; m < 2*ppcr_pkg::NUM_MON; m++) begin
        ctl_sel[m] <= ppcr_pkg::CAPT_SEL_NONE;
      end
    end else if (hit_ctl && reg_req.write) begin
      mon_enable[mon_idx] <= reg_req.wdata[ppcr_pkg::CTL_EN_BIT];
      // Without capture support the selector is held at zero.
      ctl_sel[mon_idx] <= ppcr_pkg::CAPT_SUPPORTED ?
                          reg_req.wdata[ppcr_pkg::CTL_SEL_LSB +: 3] : ppcr_pkg::CAPT_SEL_NONE;
    end
  end

  // The selector field must read back as written, since capture is present here.
  a_ctl_sel_write: assert property (hit_ctl && reg_req.write |=>
                                    ctl_sel[$past(mon_idx)] == $past(reg_req.wdata[30:28]))
    else $error("capture selector not stored");

  // Decides whether one monitor sees a capture event this cycle.
  function automatic logic cap_hit(logic [2:0] sel, logic is_ns, logic es, logic ens, logic [5:0] ext);
    logic r;
    r = 1'b0;
    if (sel == ppcr_pkg::CAPT_SEL_LOCAL) begin
      r = is_ns ? ens : es;
    end else if (sel != ppcr_pkg::CAPT_SEL_NONE) begin
      r = ppcr_pkg::EXT_EVT_IMPL[sel - 3'h1] & ext[sel - 3'h1];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Capture pulses. They do not depend on enable; gating is the monitor's.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_capture <= '0;
    end else begin
      for (int m = 0; m < 2*ppcr_pkg::NUM_MON; m++) begin
        mon_capture[m] <= cap_hit(ctl_sel[m], m >= ppcr_pkg::NUM_MON, evt_s, evt_ns,
                                  ext_capture_evt);
      end
    end
  end

  // Only the wired external source may capture; it takes one cycle.
  a_ext_capture: assert property ((ctl_sel[0] == 3'h1) && ext_capture_evt[0] |=> mon_capture[0])
    else $error("external event one missed by its monitor");

  // ----------------------------------------------------------------------
  // Read multiplexer. Unmapped addresses read zero and ignore writes.
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_ps) begin
      next_rdata = cur_ps;
    end else if (hit_pri) begin
      // A flagged access returns zero rather than a stale slot.
      next_rdata = nrw_err ? 32'h00000000 : pri_rd;
    end else if (hit_ms) begin
      next_rdata = monitor_instance_index[sec];
    end else if (hit_capt) begin
      next_rdata = 32'h00000000;
    end else if (hit_ctl) begin
      next_rdata = {mon_enable[mon_idx], ctl_sel[mon_idx], 28'h0000000};
    end else if (hit_esr) begin
      next_rdata = esr[sec];
    end
  end

  // Response follows every read by exactly one cycle; writes get no response.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.valid <= reg_req.valid && !reg_req.write;
      reg_rsp.rdata <= (reg_req.valid && !reg_req.write) ? next_rdata : 32'h00000000;
    end
  end

  // A refused priority load must answer zero, never a stale slot.
  a_refused_read: assert property (hit_pri && nrw_err && !reg_req.write |=> reg_rsp.rdata == 32'h00000000)
    else $error("refused priority load returned data");

  // ----------------------------------------------------------------------
  // Transaction priority lookup, one cycle after the request.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pri_out <= '0;
    end else begin
      pri_out.valid    <= txn.valid;
      pri_out.ds_pri   <= lk_rd[31:16];
      pri_out.int_pri  <= lk_rd[15:0];
      pri_out.ds_rank  <= ppcr_pkg::pri_rank(lk_rd[31:16], ppcr_pkg::DS_ZERO_LOW, ppcr_pkg::DS_WIDTH);
      pri_out.int_rank <= ppcr_pkg::pri_rank(lk_rd[15:0], ppcr_pkg::INT_ZERO_LOW, ppcr_pkg::INT_WIDTH);
    end
  end

  // Each lookup answers exactly one cycle later, and only then.
  a_lookup_valid: assert property (pri_out.valid == $past(txn.valid))
    else $error("priority lookup answer out of step");

  // Bits above each implemented width must never reach the fabric.
  a_lookup_width: assert property (pri_out.valid |->
                                   ((pri_out.ds_pri >> ppcr_pkg::DS_WIDTH) == 16'h0000) &&
                                   ((pri_out.int_pri >> ppcr_pkg::INT_WIDTH) == 16'h0000))
    else $error("unimplemented priority bits reached the lookup");

  // With the polarities reported here, downstream rank equals the value and internal rank is
  // its complement within the implemented width.
  a_rank_polarity: assert property (pri_out.valid |-> (pri_out.ds_rank == pri_out.ds_pri) &&
                                    ((pri_out.int_rank ^ pri_out.int_pri) ==
                                     16'((17'h00001 << ppcr_pkg::INT_WIDTH) - 17'h00001)))
    else $error("priority rank ignores polarity");

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------

  sequence s_capt_wr(logic ns, logic now_v, logic all_v);
    hit_capt && reg_req.write && (reg_req.ns == ns) && (reg_req.wdata[0] == now_v) && (reg_req.wdata[1] == all_v);
  endsequence

  sequence s_pri_wr;
    hit_pri && reg_req.write && !nrw_err;
  endsequence

  sequence s_pri_rd_same;
    hit_pri && !reg_req.write && !nrw_err && (reg_req.ns == $past(reg_req.ns, 2));
  endsequence

  a_capt_secure_only: assert property (s_capt_wr(1'b0, 1'b1, 1'b0) |=> evt_s && !evt_ns)
    else $error("secure trigger without broadcast reached wrong scope");
  a_capt_broadcast: assert property (s_capt_wr(1'b0, 1'b1, 1'b1) |=> evt_s && evt_ns)
    else $error("secure broadcast did not reach both scopes");
  a_capt_ns_scope: assert property (hit_capt && reg_req.write && reg_req.ns && reg_req.wdata[0]
                                    |=> !evt_s && evt_ns)
    else $error("non-secure trigger reached secure monitors");
  a_capt_no_trigger: assert property (hit_capt && reg_req.write && !reg_req.wdata[0] |=> !evt_s && !evt_ns)
    else $error("event raised without trigger bit");
  a_capt_read_zero: assert property (hit_capt && !reg_req.write |=> reg_rsp.valid && (reg_rsp.rdata == 32'h0))
    else $error("capture register read nonzero");
  a_local_capture: assert property (evt_s && (ctl_sel[0] == 3'h7) |=> mon_capture[0])
    else $error("selector seven monitor missed local event");
  a_pulse_single: assert property (s_capt_wr(1'b0, 1'b1, 1'b0) ##1 !hit_capt |=> !evt_s ##1 !mon_capture[0])
    else $error("capture event lasted more than one cycle");
  a_omitted_source: assert property ((ctl_sel[0] == 3'h2) && $stable(ctl_sel[0]) |=> !mon_capture[0])
    else $error("omitted event source caused capture");
  a_range_error: assert property (hit_pri && nrw_err && !reg_req.ns |=> esr[0][0])
    else $error("internal flag mismatch not logged");
  a_pri_readback: assert property (s_pri_wr ##1 !reg_req.valid ##1 s_pri_rd_same |=>
                                   reg_rsp.rdata == {ppcr_pkg::pri_mask($past(reg_req.wdata[31:16], 3),
                                                     ppcr_pkg::DS_SUPPORTED, ppcr_pkg::DS_WIDTH),
                                                     ppcr_pkg::pri_mask($past(reg_req.wdata[15:0], 3),
                                                     ppcr_pkg::INT_SUPPORTED, ppcr_pkg::INT_WIDTH)})
    else $error("priority readback mismatch");
  a_enable_write: assert property (hit_ctl && reg_req.write |=> mon_enable[$past(mon_idx)] == $past(reg_req.wdata[31]))
    else $error("monitor enable not updated");

endmodule

// >>> tb/ppcr_regs_bench.sv
`timescale 1ns/1ps
module ppcr_regs_bench;
  // ----------------------------------------
  // Bench signals and expected field values.
  // ----------------------------------------
  logic                core_clk;
  logic                rst_b;
  ppcr_pkg::ppcr_req_t rq;
  ppcr_pkg::ppcr_rsp_t rs;
  ppcr_pkg::ppcr_txn_t tx;
  ppcr_pkg::ppcr_pri_t po;
  logic [5:0]          ext;
  logic [7:0]          men;
  logic [7:0]          mcap;
  int                  miscompares;
  int                  n_compared;
  localparam logic [15:0] DS_M = 16'((17'h1 << ppcr_pkg::DS_WIDTH) - 17'h1);
  localparam logic [15:0] IN_M = 16'((17'h1 << ppcr_pkg::INT_WIDTH) - 17'h1);
  localparam logic [15:0] DSV  = DS_M & 16'hfff5; // Only the low implemented bits survive.
  localparam logic [15:0] INV  = IN_M & 16'hfff2;

  ppcr_regs u_ppcr_regs (.core_clk(core_clk), .rst_b(rst_b), .reg_req(rq), .reg_rsp(rs), .txn(tx),
    .pri_out(po), .ext_capture_evt(ext), .mon_enable(men), .mon_capture(mcap));

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [64:0] seen, logic [64:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A store is held for exactly one taking edge, then released.
  task automatic wr(logic ns, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    rq <= '{1'h1, 1'h1, ns, a, d};
    @(posedge core_clk);
    rq <= '0;
  endtask

  // A load answer stands one cycle only, so it is sampled in that cycle.
  task automatic rd(logic ns, logic [11:0] a, logic [31:0] exp);
    @(posedge core_clk);
    rq <= '{1'h1, 1'h0, ns, a, 32'h0};
    @(posedge core_clk);
    rq <= '0;
    #1;
    chk($sformatf("load %h", a), {rs.valid, rs.rdata}, {1'h1, exp});
  endtask

  // Capture shows one edge after the trigger store is taken and lasts one cycle.
  task automatic cap(logic [7:0] exp);
    @(posedge core_clk);
    #1;
    chk("capture", mcap, exp);
    @(posedge core_clk);
    #1;
    chk("capture end", mcap, 8'h00);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // The whole run needs under a hundred cycles; this bound cuts a hang.
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    rst_b = 1'h0;
    rq = '0;
    tx = '0;
    ext = 6'h00;
    miscompares = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'h1;
    rd(1'h0, 12'h808, 32'h0);
    wr(1'h0, 12'h808, 32'h2);
    cap(8'h00);
    wr(1'h0, 12'h400, 32'hffffffff);
    rd(1'h0, 12'h400, 32'h0);
    rd(1'h0, 12'h0f8, 32'h1);
    $display("test refused access done");
    wr(1'h0, 12'h100, 32'h01010003);
    rd(1'h0, 12'h100, 32'h01010003);
    wr(1'h0, 12'h400, 32'hfff5fff2);
    wr(1'h0, 12'h100, 32'h01010004);
    wr(1'h0, 12'h400, 32'h00010001);
    wr(1'h0, 12'h100, 32'h01010003);
    rd(1'h0, 12'h400, {DSV, INV});
    wr(1'h0, 12'h400, 32'hfff5fff2);
    rd(1'h0, 12'h400, {DSV, INV});
    wr(1'h1, 12'h100, 32'h01010003);
    rd(1'h1, 12'h400, 32'h0);
    @(posedge core_clk);
    tx <= '{1'h1, 1'h0, 4'h1, 16'h0003};
    @(posedge core_clk);
    tx <= '0;
    #1;
    // Downstream zero is lowest, internal zero is highest.
    chk("lookup", po, {1'h1, DSV, INV, DSV, ~INV & IN_M});
    $display("test priority done");
    wr(1'h0, 12'h818, 32'hf0000000);
    wr(1'h1, 12'h818, 32'hf0000000);
    rd(1'h0, 12'h818, 32'hf0000000);
    chk("enable", men, 8'h11);
    wr(1'h0, 12'h808, 32'h1);
    cap(8'h01);
    wr(1'h0, 12'h808, 32'h3);
    cap(8'h11);
    wr(1'h1, 12'h808, 32'h3);
    cap(8'h10);
    $display("test capture done");
    for (int k = 1; k <= 2; k++) begin
      wr(1'h0, 12'h818, {1'h1, 3'(k), 28'h0});
      @(posedge core_clk);
      ext <= 6'(1 << (k - 1));
      @(posedge core_clk);
      ext <= 6'h00;
      #1;
      chk("external", mcap, (k == 1) ? 8'h01 : 8'h00);
    end
    $display("test external done");
    wrap_up();
  end
endmodule
